/* ppadc_defs.svh */
// Register offsets, reset values and widths of the port pin configuration block
`ifndef PPADC_DEFS_SVH
`define PPADC_DEFS_SVH

`define PPADC_PIN_COUNT        16
`define PPADC_OFF_DIRECTION    12'h000
`define PPADC_OFF_PIN_LEVEL    12'h004
`define PPADC_OFF_OUT_LATCH    12'h008
`define PPADC_OFF_OPEN_DRAIN   12'h00C
`define PPADC_OFF_ANALOG_SEL   12'h010
`define PPADC_RST_DIRECTION    16'hFFFF
`define PPADC_RST_OUT_LATCH    16'h0000
`define PPADC_RST_OPEN_DRAIN   16'h0000
`define PPADC_RST_ANALOG_SEL   16'hFFFF
`define PPADC_HTRANS_NONSEQ    2'h2
`define PPADC_HTRANS_SEQ       2'h3

`endif

/* ppadc_pkg.sv */
// Types shared by the port pin configuration block
package ppadc_pkg;
  `include "ppadc_defs.svh"

  typedef logic [`PPADC_PIN_COUNT-1:0] ppadc_pins_type;

  typedef enum logic [2:0] {
    PPADC_SEL_NONE,
    PPADC_SEL_DIRECTION,
    PPADC_SEL_PIN_LEVEL,
    PPADC_SEL_OUT_LATCH,
    PPADC_SEL_OPEN_DRAIN,
    PPADC_SEL_ANALOG_SEL
  } ppadc_sel_type;

  typedef struct packed {
    logic           dataPhase;
    logic           dataWrite;
    ppadc_sel_type  sel;
    logic [31:0]    readData;
    ppadc_pins_type directionControl;
    ppadc_pins_type outputLatch;
    ppadc_pins_type openDrainSelect;
    ppadc_pins_type analogSelect;
    ppadc_pins_type pinMeta;
    ppadc_pins_type pinSync;
  } ppadc_state_type;
endpackage

/* ppadc_pin_cell.sv */
// One pin's driver and input gating from its configuration bits
`timescale 1ns/1ps
module ppadc_pin_cell (
  input  wire logic directionControl,
  input  wire logic analogSelect,
  input  wire logic openDrainSelect,
  input  wire logic outputLatch,
  input  wire logic pinSync,
  output logic      padOut,
  output logic      padOutEnable_n,
  output logic      analogOutLevel,
  output logic      analogOutValid,
  output logic      digitalIn
);
  logic driveDigital;

  // Output only when direction is output and the pin is digital
  assign driveDigital = !directionControl && !analogSelect;
  // Open drain drives only the low level, releases for a high
  assign padOut = openDrainSelect ? 1'b0 : outputLatch;
  assign padOutEnable_n = !(driveDigital && (!openDrainSelect || !outputLatch));
  // Output mode on an analog pin hands the latch level to the converter
  assign analogOutValid = !directionControl && analogSelect;
  assign analogOutLevel = analogOutValid ? outputLatch : 1'b0;
  // Analog input pins read back as low
  assign digitalIn = (directionControl && analogSelect) ? 1'b0 : pinSync;
endmodule

/* ppadc_port.sv */
// Port pin configuration block with AHB-Lite register slave
`timescale 1ns/1ps
`include "ppadc_defs.svh"
module ppadc_port
  import ppadc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] padIn,
  output logic      [15:0] padOut,
  output logic      [15:0] padOutEnable_n,
  output logic      [15:0] analogOutLevel,
  output logic      [15:0] analogOutValid,
  output logic      [15:0] digitalIn
);
  ppadc_state_type state;
  ppadc_state_type next_state;
  ppadc_pins_type  pinRead;
  ppadc_sel_type   addrSel;
  logic            addrTake;
  logic            readTake;
  logic            writeCommit;
  logic            writeDirection;
  logic            writeLatch;
  logic            writeOpenDrain;
  logic            writeAnalog;
  logic [31:0]     readMux;

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin logic

  genvar pinIdx;
  generate
    for (pinIdx = 0; pinIdx < `PPADC_PIN_COUNT; pinIdx++) begin : gPin
      ppadc_pin_cell uCell (
        .directionControl (state.directionControl[pinIdx]),
        .analogSelect     (state.analogSelect[pinIdx]),
        .openDrainSelect  (state.openDrainSelect[pinIdx]),
        .outputLatch      (state.outputLatch[pinIdx]),
        .pinSync          (state.pinSync[pinIdx]),
        .padOut           (padOut[pinIdx]),
        .padOutEnable_n   (padOutEnable_n[pinIdx]),
        .analogOutLevel   (analogOutLevel[pinIdx]),
        .analogOutValid   (analogOutValid[pinIdx]),
        .digitalIn        (pinRead[pinIdx])
      );
    end
  endgenerate

  assign digitalIn = pinRead;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign addrTake = hsel && hready &&
                    (htrans == `PPADC_HTRANS_NONSEQ || htrans == `PPADC_HTRANS_SEQ);

  always_comb begin
    if (haddr == `PPADC_OFF_DIRECTION) begin
      addrSel = PPADC_SEL_DIRECTION;
    end else if (haddr == `PPADC_OFF_PIN_LEVEL) begin
      addrSel = PPADC_SEL_PIN_LEVEL;
    end else if (haddr == `PPADC_OFF_OUT_LATCH) begin
      addrSel = PPADC_SEL_OUT_LATCH;
    end else if (haddr == `PPADC_OFF_OPEN_DRAIN) begin
      addrSel = PPADC_SEL_OPEN_DRAIN;
    end else if (haddr == `PPADC_OFF_ANALOG_SEL) begin
      addrSel = PPADC_SEL_ANALOG_SEL;
    end else begin
      addrSel = PPADC_SEL_NONE;
    end
  end

  // Reads are answered from the address phase; hsize is not checked
  assign readTake = addrTake && !hwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes

  // Data phase of an accepted write; hwdata only stands now
  assign writeCommit    = state.dataPhase && state.dataWrite;
  assign writeDirection = writeCommit && (state.sel == PPADC_SEL_DIRECTION);
  // A port write lands in the latch, never on the pin directly
  assign writeLatch     = writeCommit &&
                          (state.sel == PPADC_SEL_PIN_LEVEL ||
                           state.sel == PPADC_SEL_OUT_LATCH);
  assign writeOpenDrain = writeCommit && (state.sel == PPADC_SEL_OPEN_DRAIN);
  assign writeAnalog    = writeCommit && (state.sel == PPADC_SEL_ANALOG_SEL);

  ////////////////////////////////////////////////////////////////////////////
  // Read-back mux

  always_comb begin
    if (addrSel == PPADC_SEL_DIRECTION) begin
      readMux = {16'h0000, state.directionControl};
    end else if (addrSel == PPADC_SEL_PIN_LEVEL) begin
      // Pin level lags pins by the synchroniser, hence the settle cycle
      readMux = {16'h0000, pinRead};
    end else if (addrSel == PPADC_SEL_OUT_LATCH) begin
      readMux = {16'h0000, state.outputLatch};
    end else if (addrSel == PPADC_SEL_OPEN_DRAIN) begin
      readMux = {16'h0000, state.openDrainSelect};
    end else if (addrSel == PPADC_SEL_ANALOG_SEL) begin
      readMux = {16'h0000, state.analogSelect};
    end else begin
      // Holes read as zero rather than an error response
      readMux = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state = state;
    // Two-stage pin synchroniser; only the second stage is read
    next_state.pinMeta = padIn;
    next_state.pinSync = state.pinMeta;
    // Write data arrives in the data phase
    if (writeDirection) begin
      next_state.directionControl = hwdata[15:0];
    end
    if (writeLatch) begin
      next_state.outputLatch = hwdata[15:0];
    end
    if (writeOpenDrain) begin
      next_state.openDrainSelect = hwdata[15:0];
    end
    if (writeAnalog) begin
      next_state.analogSelect = hwdata[15:0];
    end
    next_state.dataPhase = addrTake;
    next_state.dataWrite = addrTake && hwrite;
    next_state.sel = addrTake ? addrSel : PPADC_SEL_NONE;
    // Read data registered at the address phase, zero in every other cycle
    next_state.readData = 32'h0000_0000;
    if (readTake) begin
      next_state.readData = readMux;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.dataPhase        <= 1'b0;
      state.dataWrite        <= 1'b0;
      state.sel              <= PPADC_SEL_NONE;
      state.readData         <= 32'h0000_0000;
      state.directionControl <= `PPADC_RST_DIRECTION;
      state.outputLatch      <= `PPADC_RST_OUT_LATCH;
      state.openDrainSelect  <= `PPADC_RST_OPEN_DRAIN;
      state.analogSelect     <= `PPADC_RST_ANALOG_SEL;
      state.pinMeta          <= 16'h0000;
      state.pinSync          <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  assign hrdata    = state.readData;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule

/* ppadc_port_sva.sv */
// Checker for the port pin configuration block
`timescale 1ns/1ps
module ppadc_port_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] padIn,
  input wire logic [15:0] padOutEnable_n,
  input wire logic [15:0] analogOutLevel,
  input wire logic [15:0] analogOutValid,
  input wire logic [15:0] digitalIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_state: assert property ($fell(sys_rst) |->
    padOutEnable_n == 16'hFFFF && analogOutValid == 16'h0000) else $error("bad reset state");
  a_analog_undriven: assert property ((analogOutValid & ~padOutEnable_n) == 16'h0000)
    else $error("analog pin driven");
  a_level_gated: assert property ((analogOutLevel & ~analogOutValid) == 16'h0000)
    else $error("level without valid");
  // Two-flop sync: a high input bit must have been high two edges back
  a_input_sync: assert property ((digitalIn & ~$past(padIn, 2)) == 16'h0000)
    else $error("input not from pin");
  a_cfg_cause: assert property ($changed(padOutEnable_n) |->
    $past(hsel && htrans[1] && hwrite, 2)) else $error("enable moved without write");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
  c_write: cover property (hsel && htrans[1] && hwrite);
  c_analog: cover property (analogOutValid != 16'h0000);
  c_digin: cover property (digitalIn != 16'h0000);
endmodule
bind ppadc_port ppadc_port_sva u_sva (.clk, .sys_rst, .hsel, .htrans, .hwrite, .hreadyout,
  .hresp, .padIn, .padOutEnable_n, .analogOutLevel, .analogOutValid, .digitalIn);

/* ppadc_pin_model.sv */
// External circuit on the pins: pull-ups plus an optional outside driver
`timescale 1ns/1ps
module ppadc_pin_model (
  input  wire logic [15:0] padOut,
  input  wire logic [15:0] padOutEnable_n,
  input  wire logic [15:0] extLevel,
  input  wire logic [15:0] extEnable,
  output logic      [15:0] padIn
);
  // Released pins float up unless the outside driver pulls them
  assign padIn = (~padOutEnable_n & padOut) |
                 (padOutEnable_n & ((extEnable & extLevel) | ~extEnable));
endmodule

/* tb_top.sv */
// Self-checking bench for the port pin configuration block
`timescale 1ns/1ps
module tb_top;
  import ppadc_pkg::*;
  `include "ppadc_defs.svh"
  logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] padIn, padOut, padOutEnable_n, analogOutLevel, analogOutValid, digitalIn;
  logic [15:0] extLevel, extEnable;
  int          num_errors, samples_checked, cycles;
  ppadc_port DUT (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .padIn, .padOut, .padOutEnable_n,
    .analogOutLevel, .analogOutValid, .digitalIn);
  ppadc_pin_model u_pins (.padOut, .padOutEnable_n, .extLevel, .extEnable, .padIn);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Entry edge leaves one idle cycle between transfers
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic t_reset();
    rdchk("dir", `PPADC_OFF_DIRECTION, 32'h0000FFFF);
    rdchk("ana", `PPADC_OFF_ANALOG_SEL, 32'h0000FFFF);
    rdchk("lat", `PPADC_OFF_OUT_LATCH, 32'h0);
    rdchk("odc", `PPADC_OFF_OPEN_DRAIN, 32'h0);
    rdchk("pins", `PPADC_OFF_PIN_LEVEL, 32'h0);
    rdchk("hole", 12'h020, 32'h0);
    chk("okay", 32'h2, {hreadyout, hresp});
    $display("reset test done");
  endtask
  task automatic t_digital();
    bus(1'b1, `PPADC_OFF_ANALOG_SEL, 32'h0);
    bus(1'b1, `PPADC_OFF_PIN_LEVEL, 32'h00A5);
    bus(1'b1, `PPADC_OFF_DIRECTION, 32'hFF00);
    repeat (3) @(posedge clk);
    chk("oen", 32'hFF00, padOutEnable_n);
    chk("out", 32'h00A5, padOut & 16'h00FF);
    chk("din", 32'hFFA5, digitalIn);
    chk("aval", 32'h0, analogOutValid);
    chk("alvl", 32'h0, analogOutLevel);
    rdchk("pins", `PPADC_OFF_PIN_LEVEL, 32'hFFA5);
    rdchk("lat", `PPADC_OFF_OUT_LATCH, 32'h00A5);
    $display("digital test done");
  endtask
  task automatic t_open_drain();
    extEnable <= 16'h0001;
    bus(1'b1, `PPADC_OFF_OPEN_DRAIN, 32'h000F);
    repeat (3) @(posedge clk);
    chk("oen", 32'hFF05, padOutEnable_n);
    chk("out", 32'h00A0, padOut & 16'h00FF);
    rdchk("pins", `PPADC_OFF_PIN_LEVEL, 32'hFFA4);
    extEnable <= 16'h0000;
    bus(1'b1, `PPADC_OFF_OPEN_DRAIN, 32'h0);
    $display("open drain test done");
  endtask
  task automatic t_analog();
    bus(1'b1, `PPADC_OFF_DIRECTION, 32'h00F0);
    bus(1'b1, `PPADC_OFF_ANALOG_SEL, 32'h00F0);
    repeat (3) @(posedge clk);
    rdchk("pins", `PPADC_OFF_PIN_LEVEL, 32'h0005);
    chk("din", 32'h0, digitalIn & 16'h00F0);
    chk("aval", 32'h0, analogOutValid);
    bus(1'b1, `PPADC_OFF_DIRECTION, 32'h0);
    repeat (3) @(posedge clk);
    chk("aval", 32'h00F0, analogOutValid);
    chk("alvl", 32'h00A0, analogOutLevel);
    chk("oen", 32'h00F0, padOutEnable_n);
    $display("analog test done");
  endtask
  initial begin
    {sys_rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 48'h0};
    {extLevel, extEnable, num_errors, samples_checked, cycles} = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_digital();
    t_open_drain();
    t_analog();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    final_report();
  end
endmodule
